// File: torque_limit_selector.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
module torque_limit_selector #(
  parameter int                         TW            = 12,
  parameter logic [tls_pkg::LIM_W-1:0]  MOTOR_MAX_PCT = 10'h12C
) (
  input  wire logic                          MCLK,
  input  wire logic                          RESETN,
  input  wire logic [tls_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic [tls_pkg::DATA_W-1:0]    WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [tls_pkg::DATA_W-1:0]    RDATA,
  input  wire logic                          FWD_EXT_LIMIT_REQ_N,
  input  wire logic                          REV_EXT_LIMIT_REQ_N,
  input  wire logic signed [TW-1:0]          TORQ_REF,
  input  wire logic                          AUX_STATUS,
  output logic signed [TW-1:0]               TORQ_OUT,
  output logic                               TORQUE_LIMITING_FLAG,
  output logic      [tls_pkg::NUM_CIRCUITS-1:0] OUTPUT_CIRCUIT_N,
  output logic                               IRQ
);

  if (TW < 12)
  begin : g_bad_width
    $error("TW must be at least 12 to hold +-800 percent");
  end

  typedef struct packed {
    logic [1:0]                          fwd_sync;
    logic [1:0]                          rev_sync;
    logic                                fwd_prev;
    logic                                rev_prev;
    logic [tls_pkg::LIM_W-1:0]           fwd_int;
    logic [tls_pkg::LIM_W-1:0]           rev_int;
    logic [tls_pkg::LIM_W-1:0]           fwd_ext;
    logic [tls_pkg::LIM_W-1:0]           rev_ext;
    logic [tls_pkg::LIM_W-1:0]           max_t;
    logic [tls_pkg::DATA_W-1:0]          sel;
    logic [2:0]                          irq_st;
    logic [2:0]                          irq_en;
    logic                                irq;
    logic [tls_pkg::DATA_W-1:0]          rdata;
    logic [TW-1:0]                       torq;
    logic                                lim;
    logic [tls_pkg::NUM_CIRCUITS-1:0]    circ_n;
  } tls_state_t;

  tls_state_t s_q;
  tls_state_t s_d;

  tls_limit_if #(.TW(TW)) lif ();

  tls_limit_calc #(.TW(TW)) u_calc (
    .lif (lif)
  );

  logic [tls_pkg::ROUTE_W-1:0]         flag_route;
  logic [tls_pkg::ROUTE_W-1:0]         aux_route;
  logic [tls_pkg::NUM_CIRCUITS-1:0]    circ_on;
  logic [2:0]                          irq_ev;
  logic [2:0]                          irq_clr;

  function automatic logic [tls_pkg::LIM_W-1:0] clamp_set(input logic [tls_pkg::DATA_W-1:0] w);
    clamp_set = (w > {6'h00, tls_pkg::LIMIT_MAX_PCT}) ? tls_pkg::LIMIT_MAX_PCT
                                                      : w[tls_pkg::LIM_W-1:0];
  endfunction : clamp_set

  // synchronised requests are active low at the pins
  assign lif.fwd_req  = ~s_q.fwd_sync[1];
  assign lif.rev_req  = ~s_q.rev_sync[1];
  assign lif.fwd_int  = s_q.fwd_int;
  assign lif.rev_int  = s_q.rev_int;
  assign lif.fwd_ext  = s_q.fwd_ext;
  assign lif.rev_ext  = s_q.rev_ext;
  assign lif.max_t    = s_q.max_t;
  assign lif.torq_ref = TORQ_REF;

  assign flag_route = s_q.sel[tls_pkg::ROUTE_FLAG_LSB +: tls_pkg::ROUTE_W];
  assign aux_route  = s_q.sel[tls_pkg::ROUTE_AUX_LSB +: tls_pkg::ROUTE_W];

  // one circuit per route code 1 to 3 (other codes drive none), every source OR-ed in
  for (genvar i = 0; i < tls_pkg::NUM_CIRCUITS; i++)
  begin : g_circ
    assign circ_on[i] = (lif.over && flag_route == tls_pkg::ROUTE_W'(i + 1)) ||
                        (AUX_STATUS && aux_route == tls_pkg::ROUTE_W'(i + 1));
  end

  always_comb
  begin
    s_d = s_q;
    s_d.fwd_sync = {s_q.fwd_sync[0], FWD_EXT_LIMIT_REQ_N};
    s_d.rev_sync = {s_q.rev_sync[0], REV_EXT_LIMIT_REQ_N};
    s_d.fwd_prev = s_q.fwd_sync[1];
    s_d.rev_prev = s_q.rev_sync[1];
    s_d.torq = lif.torq_clamped;
    s_d.lim = lif.over;
    s_d.circ_n = ~circ_on;
    irq_clr = 3'h0;
    if (WR)
    begin
      case (ADDR)
        tls_pkg::OFS_FWD_INTERNAL_LIMIT: s_d.fwd_int = clamp_set(WDATA);
        tls_pkg::OFS_REV_INTERNAL_LIMIT: s_d.rev_int = clamp_set(WDATA);
        tls_pkg::OFS_FWD_EXTERNAL_LIMIT: s_d.fwd_ext = clamp_set(WDATA);
        tls_pkg::OFS_REV_EXTERNAL_LIMIT: s_d.rev_ext = clamp_set(WDATA);
        tls_pkg::OFS_OUTPUT_SELECT_2:    s_d.sel = WDATA;
        tls_pkg::OFS_MOTOR_MAX_TORQUE:   s_d.max_t = clamp_set(WDATA);
        tls_pkg::OFS_IRQ_CLEAR:          irq_clr = WDATA[2:0];
        tls_pkg::OFS_IRQ_ENABLE:         s_d.irq_en = WDATA[2:0];
        default:                         s_d.sel = s_q.sel;
      endcase
    end
    irq_ev = 3'h0;
    irq_ev[tls_pkg::IRQ_LIMIT_BIT] = lif.over && !s_q.lim;
    irq_ev[tls_pkg::IRQ_FWD_BIT] = s_q.fwd_sync[1] != s_q.fwd_prev;
    irq_ev[tls_pkg::IRQ_REV_BIT] = s_q.rev_sync[1] != s_q.rev_prev;
    // a new event wins over a clear in the same cycle
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_en);
    s_d.rdata = '0;
    if (RD)
    begin
      case (ADDR)
        tls_pkg::OFS_FWD_INTERNAL_LIMIT: s_d.rdata = {6'h00, s_q.fwd_int};
        tls_pkg::OFS_REV_INTERNAL_LIMIT: s_d.rdata = {6'h00, s_q.rev_int};
        tls_pkg::OFS_FWD_EXTERNAL_LIMIT: s_d.rdata = {6'h00, s_q.fwd_ext};
        tls_pkg::OFS_REV_EXTERNAL_LIMIT: s_d.rdata = {6'h00, s_q.rev_ext};
        tls_pkg::OFS_OUTPUT_SELECT_2:    s_d.rdata = s_q.sel;
        tls_pkg::OFS_MOTOR_MAX_TORQUE:   s_d.rdata = {6'h00, s_q.max_t};
        tls_pkg::OFS_INPUT_MONITOR:
        begin
          s_d.rdata[tls_pkg::IN_MON_FWD_BIT] = lif.fwd_req;
          s_d.rdata[tls_pkg::IN_MON_REV_BIT] = lif.rev_req;
        end
        tls_pkg::OFS_OUTPUT_MONITOR:
        begin
          s_d.rdata[tls_pkg::NUM_CIRCUITS-1:0] = ~s_q.circ_n;
          s_d.rdata[tls_pkg::OUT_MON_FLAG_BIT] = s_q.lim;
        end
        tls_pkg::OFS_IRQ_STATUS:         s_d.rdata = {13'h0000, s_q.irq_st};
        tls_pkg::OFS_IRQ_ENABLE:         s_d.rdata = {13'h0000, s_q.irq_en};
        default:                         s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      s_q <= '0;
      s_q.fwd_sync <= 2'h3;
      s_q.rev_sync <= 2'h3;
      s_q.fwd_prev <= 1'b1;
      s_q.rev_prev <= 1'b1;
      s_q.fwd_int <= tls_pkg::RST_INTERNAL_LIMIT;
      s_q.rev_int <= tls_pkg::RST_INTERNAL_LIMIT;
      s_q.fwd_ext <= tls_pkg::RST_EXTERNAL_LIMIT;
      s_q.rev_ext <= tls_pkg::RST_EXTERNAL_LIMIT;
      s_q.max_t <= MOTOR_MAX_PCT;
      s_q.sel <= tls_pkg::RST_OUTPUT_SELECT;
      s_q.irq_en <= tls_pkg::RST_IRQ_ENABLE;
      s_q.circ_n <= 3'h7;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign TORQ_OUT = $signed(s_q.torq);
  assign TORQUE_LIMITING_FLAG = s_q.lim;
  assign OUTPUT_CIRCUIT_N = s_q.circ_n;
  assign IRQ = s_q.irq;

  // helper views for the checks below
  logic signed [TW-1:0]      fwd_s_h;
  logic signed [TW-1:0]      rev_s_h;
  logic [tls_pkg::LIM_W-1:0] fwd_base_h;
  logic [tls_pkg::LIM_W-1:0] rev_base_h;
  assign fwd_s_h = $signed({{(TW-tls_pkg::LIM_W){1'b0}}, lif.fwd_eff});
  assign rev_s_h = $signed({{(TW-tls_pkg::LIM_W){1'b0}}, lif.rev_eff});
  assign fwd_base_h = tls_pkg::min_lim(s_q.fwd_int, s_q.max_t);
  assign rev_base_h = tls_pkg::min_lim(s_q.rev_int, s_q.max_t);

  sequence s_fwd_held;
    !FWD_EXT_LIMIT_REQ_N [*4];
  endsequence
  sequence s_rev_held;
    !REV_EXT_LIMIT_REQ_N [*4];
  endsequence
  sequence s_in_mon_read;
    RD && ADDR == tls_pkg::OFS_INPUT_MONITOR;
  endsequence

  a_fwd_clamp: assert property (@(posedge MCLK) disable iff (!RESETN)
    (TORQ_REF > fwd_s_h) |=> (TORQ_OUT == $past(fwd_s_h)))
    else $error("forward torque not clamped to its limit");

  a_rev_clamp: assert property (@(posedge MCLK) disable iff (!RESETN)
    (TORQ_REF < -rev_s_h) |=> (TORQ_OUT == -$past(rev_s_h)))
    else $error("reverse torque not clamped to its limit");

  a_flag_follows: assert property (@(posedge MCLK) disable iff (!RESETN)
    ##1 (TORQUE_LIMITING_FLAG ==
         ($past(TORQ_REF) > $past(fwd_s_h) || $past(TORQ_REF) < -$past(rev_s_h))))
    else $error("limiting flag does not match reference against limit");

  a_max_cap: assert property (@(posedge MCLK) disable iff (!RESETN)
    lif.fwd_eff <= s_q.max_t && lif.rev_eff <= s_q.max_t)
    else $error("effective limit above motor maximum");

  a_route_none: assert property (@(posedge MCLK) disable iff (!RESETN)
    (flag_route == 4'h0 && aux_route == 4'h0) |=> (OUTPUT_CIRCUIT_N == 3'h7))
    else $error("a circuit is driven with no route selected");

  a_route_or: assert property (@(posedge MCLK) disable iff (!RESETN)
    (AUX_STATUS && aux_route == 4'h2) |=> !OUTPUT_CIRCUIT_N[1])
    else $error("shared circuit misses the second source");

  a_flag_route: assert property (@(posedge MCLK) disable iff (!RESETN)
    (flag_route == 4'h3 && aux_route == 4'h0) |=>
      (OUTPUT_CIRCUIT_N == {~TORQUE_LIMITING_FLAG, 2'h3}))
    else $error("flag not routed to circuit three");

  a_fwd_ext: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_fwd_held |-> (lif.fwd_eff == tls_pkg::min_lim(fwd_base_h, s_q.fwd_ext)))
    else $error("forward external limit not applied");

  a_rev_ext: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_rev_held |-> (lif.rev_eff == tls_pkg::min_lim(rev_base_h, s_q.rev_ext)))
    else $error("reverse external limit not applied");

  a_ext_release: assert property (@(posedge MCLK) disable iff (!RESETN)
    (FWD_EXT_LIMIT_REQ_N && REV_EXT_LIMIT_REQ_N) [*4] |->
      (lif.fwd_eff == fwd_base_h && lif.rev_eff == rev_base_h))
    else $error("external limit used without request");

  a_ext_smaller: assert property (@(posedge MCLK) disable iff (!RESETN)
    lif.fwd_req |-> (lif.fwd_eff <= s_q.fwd_int && lif.fwd_eff <= s_q.fwd_ext))
    else $error("requested limit is not the smaller one");

  a_in_monitor: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_in_mon_read |=> (RDATA[tls_pkg::IN_MON_FWD_BIT] == $past(lif.fwd_req) &&
                       RDATA[tls_pkg::IN_MON_REV_BIT] == $past(lif.rev_req)))
    else $error("input monitor does not show the requests");

endmodule : torque_limit_selector

// File: tls_pkg.sv
package tls_pkg;

  localparam int LIM_W = 10;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int ROUTE_W = 4;

  // setting range of every torque limit, in percent of rated torque
  localparam logic [LIM_W-1:0] LIMIT_MAX_PCT = 10'h320;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FWD_INTERNAL_LIMIT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REV_INTERNAL_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FWD_EXTERNAL_LIMIT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_REV_EXTERNAL_LIMIT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_SELECT_2    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MOTOR_MAX_TORQUE   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INPUT_MONITOR      = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_MONITOR     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS         = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR          = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE         = 8'h28;

  // reset values
  localparam logic [LIM_W-1:0] RST_INTERNAL_LIMIT = 10'h320;
  localparam logic [LIM_W-1:0] RST_EXTERNAL_LIMIT = 10'h064;
  localparam logic [DATA_W-1:0] RST_OUTPUT_SELECT = 16'h0000;
  localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

  // field positions
  localparam int ROUTE_FLAG_LSB = 0;
  localparam int ROUTE_AUX_LSB = 4;
  localparam int IN_MON_FWD_BIT = 6;
  localparam int IN_MON_REV_BIT = 7;
  localparam int OUT_MON_FLAG_BIT = 3;
  localparam int IRQ_LIMIT_BIT = 0;
  localparam int IRQ_FWD_BIT = 1;
  localparam int IRQ_REV_BIT = 2;
  localparam int NUM_CIRCUITS = 3;

  function automatic logic [LIM_W-1:0] min_lim(input logic [LIM_W-1:0] a,
                                                input logic [LIM_W-1:0] b);
    min_lim = (a < b) ? a : b;
  endfunction : min_lim

endpackage : tls_pkg

// File: tls_limit_if.sv
interface tls_limit_if #(parameter int TW = 12);
  logic        [tls_pkg::LIM_W-1:0] fwd_int;
  logic        [tls_pkg::LIM_W-1:0] rev_int;
  logic        [tls_pkg::LIM_W-1:0] fwd_ext;
  logic        [tls_pkg::LIM_W-1:0] rev_ext;
  logic        [tls_pkg::LIM_W-1:0] max_t;
  logic                             fwd_req;
  logic                             rev_req;
  logic signed [TW-1:0]             torq_ref;
  logic        [tls_pkg::LIM_W-1:0] fwd_eff;
  logic        [tls_pkg::LIM_W-1:0] rev_eff;
  logic signed [TW-1:0]             torq_clamped;
  logic                             over;

  modport calc (
    input  fwd_int, rev_int, fwd_ext, rev_ext, max_t, fwd_req, rev_req, torq_ref,
    output fwd_eff, rev_eff, torq_clamped, over
  );
  modport ctrl (
    output fwd_int, rev_int, fwd_ext, rev_ext, max_t, fwd_req, rev_req, torq_ref,
    input  fwd_eff, rev_eff, torq_clamped, over
  );
endinterface : tls_limit_if

// File: tls_limit_calc.sv
module tls_limit_calc #(
  parameter int TW = 12
) (
  tls_limit_if.calc lif
);

  logic        [tls_pkg::LIM_W-1:0] fwd_base;
  logic        [tls_pkg::LIM_W-1:0] rev_base;
  logic signed [TW-1:0]             fwd_s;
  logic signed [TW-1:0]             rev_s;

  always_comb
  begin
    // settings above the motor maximum fall back to the maximum
    fwd_base = tls_pkg::min_lim(lif.fwd_int, lif.max_t);
    rev_base = tls_pkg::min_lim(lif.rev_int, lif.max_t);
    // external limit only while its request is active, never above internal
    lif.fwd_eff = lif.fwd_req ? tls_pkg::min_lim(fwd_base, lif.fwd_ext) : fwd_base;
    lif.rev_eff = lif.rev_req ? tls_pkg::min_lim(rev_base, lif.rev_ext) : rev_base;
    // limits and reference share the unit percent of rated torque
    fwd_s = $signed({{(TW-tls_pkg::LIM_W){1'b0}}, lif.fwd_eff});
    rev_s = $signed({{(TW-tls_pkg::LIM_W){1'b0}}, lif.rev_eff});
    // clamp each direction separately and flag it
    lif.over = 1'b0;
    lif.torq_clamped = lif.torq_ref;
    if (lif.torq_ref > fwd_s)
    begin
      lif.torq_clamped = fwd_s;
      lif.over = 1'b1;
    end
    else if (lif.torq_ref < -rev_s)
    begin
      lif.torq_clamped = -rev_s;
      lif.over = 1'b1;
    end
  end

endmodule : tls_limit_calc

// File: tls_host_model.sv
module tls_host_model (
  input  wire logic mclk,
  input  wire logic fwd_on,
  input  wire logic rev_on,
  output logic      fwd_req_n,
  output logic      rev_req_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // contacts are held closed (low) for as long as limiting is wanted
  always_ff @(posedge mclk)
  begin
    fwd_req_n <= !fwd_on;
    rev_req_n <= !rev_on;
  end
endmodule : tls_host_model

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk;
  logic               resetn;
  logic        [7:0]  addr;
  logic        [15:0] wdata;
  logic               wr_stb;
  logic               rd_stb;
  logic        [15:0] rdata;
  logic               fwd_on;
  logic               rev_on;
  logic               fwd_n;
  logic               rev_n;
  logic signed [11:0] torq_ref;
  logic               aux;
  logic signed [11:0] torq_out;
  logic               flag;
  logic        [2:0]  circ_n;
  logic               irq;
  int                 failures;
  int                 compares;
  logic        [7:0]  rst_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28, 8'h30};
  logic        [15:0] rst_v [7] = '{16'h0320, 16'h0320, 16'h0064, 16'h0064, 16'h0000,
                                    16'h0000, 16'h0000};
  logic        [2:0]  route_n [4] = '{3'h7, 3'h6, 3'h5, 3'h3};

  torque_limit_selector DUT (
    .MCLK                 (mclk),
    .RESETN               (resetn),
    .ADDR                 (addr),
    .WDATA                (wdata),
    .WR                   (wr_stb),
    .RD                   (rd_stb),
    .RDATA                (rdata),
    .FWD_EXT_LIMIT_REQ_N  (fwd_n),
    .REV_EXT_LIMIT_REQ_N  (rev_n),
    .TORQ_REF             (torq_ref),
    .AUX_STATUS           (aux),
    .TORQ_OUT             (torq_out),
    .TORQUE_LIMITING_FLAG (flag),
    .OUTPUT_CIRCUIT_N     (circ_n),
    .IRQ                  (irq)
  );

  tls_host_model host (
    .mclk      (mclk),
    .fwd_on    (fwd_on),
    .rev_on    (rev_on),
    .fwd_req_n (fwd_n),
    .rev_req_n (rev_n)
  );

  always #10 mclk = !mclk;

  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : bus_write

  // read data stand only in the cycle right after the strobe
  task automatic bus_read(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask : bus_read

  task automatic set_ref(input logic signed [11:0] v, input logic signed [11:0] exp,
                         input logic f);
    @(posedge mclk);
    torq_ref <= v;
    settle(3);
    chk("torq_out", {4'h0, torq_out}, {4'h0, exp});
    chk("flag", {15'h0, flag}, {15'h0, f});
  endtask : set_ref

  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  initial
  begin
    mclk = 1'b0;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fwd_on = 1'b0;
    rev_on = 1'b0;
    torq_ref = 12'h000;
    aux = 1'b0;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    settle(4);
    chk("circ_idle", {13'h0, circ_n}, 16'h0007);
    for (int i = 0; i < 7; i++) bus_read(rst_a[i], rst_v[i]);
    set_ref(12'h190, 12'h12C, 1'b1);
    for (int r = 0; r < 4; r++)
    begin
      bus_write(8'h10, 16'(r));
      settle(3);
      chk("circuit", {13'h0, circ_n}, {13'h0, route_n[r]});
      bus_read(8'h1C, {12'h0, 1'b1, ~route_n[r]});
    end
    set_ref(12'h12C, 12'h12C, 1'b0);
    set_ref(-12'sh190, -12'sh12C, 1'b1);
    bus_write(8'h10, 16'h0011);
    aux <= 1'b1;
    set_ref(12'h000, 12'h000, 1'b0);
    chk("aux_or", {13'h0, circ_n}, 16'h0006);
    set_ref(12'h190, 12'h12C, 1'b1);
    chk("or_both", {13'h0, circ_n}, 16'h0006);
    bus_write(8'h10, 16'h0021);
    set_ref(12'h190, 12'h12C, 1'b1);
    chk("two_circ", {13'h0, circ_n}, 16'h0004);
    aux <= 1'b0;
    bus_write(8'h00, 16'h03FF);
    bus_read(8'h00, 16'h0320);
    bus_write(8'h00, 16'h00C8);
    set_ref(12'h190, 12'h0C8, 1'b1);
    bus_write(8'h08, 16'h00FA);
    fwd_on <= 1'b1;
    set_ref(12'h190, 12'h0C8, 1'b1);
    bus_read(8'h18, 16'h0040);
    bus_write(8'h00, 16'h0320);
    set_ref(12'h190, 12'h0FA, 1'b1);
    fwd_on <= 1'b0;
    settle(3);
    set_ref(12'h190, 12'h12C, 1'b1);
    bus_write(8'h0C, 16'h0078);
    rev_on <= 1'b1;
    set_ref(-12'sh190, -12'sh078, 1'b1);
    bus_read(8'h18, 16'h0080);
    rev_on <= 1'b0;
    settle(3);
    set_ref(-12'sh190, -12'sh12C, 1'b1);
    set_ref(12'h000, 12'h000, 1'b0);
    // limiting began and both requests changed since reset
    bus_read(8'h20, 16'h0007);
    bus_write(8'h24, 16'h0007);
    bus_write(8'h28, 16'h0001);
    set_ref(12'h190, 12'h12C, 1'b1);
    settle(2);
    chk("irq_set", {15'h0, irq}, 16'h0001);
    bus_read(8'h20, 16'h0001);
    bus_write(8'h28, 16'h0000);
    settle(2);
    chk("irq_mask", {15'h0, irq}, 16'h0000);
    bus_write(8'h28, 16'h0001);
    settle(2);
    chk("irq_unmask", {15'h0, irq}, 16'h0001);
    bus_write(8'h24, 16'h0001);
    settle(2);
    chk("irq_clear", {15'h0, irq}, 16'h0000);
    bus_read(8'h20, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
